// File: src/ucie_defs.svh
// constants of the serial control block: register indices, field positions, timing counts
// assumes inclusion by bare name from the package, from the top module and from the port checker
`ifndef UCIE_DEFS_SVH
`define UCIE_DEFS_SVH
// register indices; byte address is four times the index
`define UCIE_IDX_ASTAT 6'h00
`define UCIE_IDX_AIRQ  6'h01
`define UCIE_IDX_AFEAT 6'h02
`define UCIE_IDX_CTRL  6'h03
`define UCIE_IDX_CFG   6'h08
`define UCIE_IDX_FLAGS 6'h09
`define UCIE_RST_REG   8'h00
// tx_rx_control fields
`define UCIE_B_EMPTY_EN 7
`define UCIE_B_DONE_EN  6
`define UCIE_B_FULL_EN  5
`define UCIE_B_IDLE_EN  4
`define UCIE_B_TXON     3
`define UCIE_B_RXON     2
`define UCIE_B_SLEEP    1
`define UCIE_B_BRKSND   0
// alt_irq_enable and alternative status fields
`define UCIE_B_EDGE 7
`define UCIE_B_BERV 2
`define UCIE_B_BERR 1
`define UCIE_B_BRK  0
// alt_feature_control fields
`define UCIE_B_IRON 7
`define UCIE_B_TNPH 6
`define UCIE_B_TNPL 5
`define UCIE_B_BEMH 2
`define UCIE_B_BEML 1
`define UCIE_B_BKDF 0
// own configuration fields
`define UCIE_B_MAPSEL 0
`define UCIE_B_LBRK 1
`define UCIE_B_WL9  2
`define UCIE_B_RPOL 3
// 32 ticks per bit; 16x tick n is 32x count 2*(n-1)
`define UCIE_TICK_LAST 5'h1f
`define UCIE_POS_S9    5'h10
`define UCIE_POS_S13   5'h18
`define UCIE_POS_MID   5'h10
`define UCIE_PW_3_16   5'h06
`define UCIE_PW_1_16   5'h02
`define UCIE_PW_1_32   5'h01
`define UCIE_PW_1_4    5'h08
// frame and break lengths in bits
`define UCIE_FRAME8    4'ha
`define UCIE_FRAME9    4'hb
`define UCIE_LBRK8     4'hd
`define UCIE_LBRK9     4'he
`endif

// File: src/ucie_pkg.sv
// types and shared decoders of the serial control block
// assumes ucie_defs.svh on the include path
`default_nettype none
package ucie_pkg;
`include "ucie_defs.svh"
	typedef logic [7:0] ucie_reg_t;
	typedef enum logic [1:0] {
		SEQ_IDLE     = 2'b00,
		SEQ_PREAMBLE = 2'b01,
		SEQ_BREAK    = 2'b10
	} ucie_seq_t;
	typedef enum logic [1:0] {
		BERR_OFF  = 2'b00,
		BERR_AT9  = 2'b01,
		BERR_AT13 = 2'b10,
		BERR_RSVD = 2'b11
	} ucie_berr_t;

	function automatic logic [3:0] ucie_frame_len(input logic word9);
		return word9 ? `UCIE_FRAME9 : `UCIE_FRAME8;
	endfunction

	function automatic logic [3:0] ucie_break_len(input logic word9, input logic long_brk);
		if (long_brk)
			return word9 ? `UCIE_LBRK9 : `UCIE_LBRK8;
		return ucie_frame_len(word9);
	endfunction
endpackage
`default_nettype wire

// File: src/ucie_seq_if.sv
// carrier between the control registers and the line sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface ucie_seq_if;
	logic       tick;
	logic       tx_on;
	logic       break_send;
	logic       long_break;
	logic       word9;
	logic       data_bit;
	logic       line;
	logic       busy;
	logic [4:0] pos;
	modport seq (input tick, tx_on, break_send, long_break, word9, data_bit,
		output line, busy, pos);
	modport ctl (output tick, tx_on, break_send, long_break, word9, data_bit,
		input line, busy, pos);
endinterface
`default_nettype wire

// File: src/ucie_top.sv
// serial control registers, interrupt enables, break and bit-error logic
// assumes a classic Wishbone master, a 32-per-bit TICK32 enable from the baud
// generator, and status flags from the receiver and transmitter
`timescale 1ns/1ns
`default_nettype none
`include "ucie_defs.svh"

module ucie_top (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 SRST,
	// wishbone slave
	input  wire logic                 WB_CYC,
	input  wire logic                 WB_STB,
	input  wire logic                 WB_WE,
	input  wire logic [7:0]           WB_ADR,
	input  wire logic [3:0]           WB_SEL,
	input  wire logic [31:0]          WB_DAT_I,
	output logic      [31:0]          WB_DAT_O,
	output logic                      WB_ACK,
	// serial pins
	input  wire logic                 RXD,
	output logic                      TXD_O,
	output logic                      TXD_OE,
	// baud and shifter side
	input  wire logic                 TICK32,
	input  wire logic                 TX_DATA_BIT,
	input  wire logic                 WAKE_EVENT,
	// status flags of the rest of the interface
	input  wire logic                 TX_EMPTY,
	input  wire logic                 TX_DONE,
	input  wire logic                 RX_FULL,
	input  wire logic                 OVERRUN,
	input  wire logic                 IDLE_LINE,
	// controls to the rest of the interface
	output ucie_pkg::ucie_reg_t       CTRL_STATE,
	output logic                      TX_BUSY,
	output logic                      IRQ
);
	import ucie_pkg::*;

	ucie_reg_t  tx_rx_control;
	ucie_reg_t  alt_irq_enable;
	ucie_reg_t  alt_feature_control;
	ucie_reg_t  cfg;
	logic [2:0] alt_flags;
	logic [2:0] alt_set;
	logic       bit_err_val;
	logic       rx_prev;
	logic       rx_lvl;
	logic [3:0] low_run;
	logic       acc;
	logic       wr;
	logic [5:0] idx;
	logic       alt_map_select;
	logic       mid_tick;
	logic       berr_tick;
	ucie_berr_t bit_err_mode;
	logic [4:0] pulse_w;
	logic [31:0] next_dat;
	logic       next_irq;

	ucie_seq_if sb ();

	assign acc            = WB_CYC && WB_STB && !WB_ACK;
	assign wr             = acc && WB_WE && WB_SEL[0];
	assign idx            = WB_ADR[7:2];
	assign alt_map_select = cfg[`UCIE_B_MAPSEL];
	assign bit_err_mode   = ucie_berr_t'(alt_feature_control[`UCIE_B_BEMH:`UCIE_B_BEML]);
	assign rx_lvl         = RXD ^ cfg[`UCIE_B_RPOL];
	assign mid_tick       = TICK32 && (sb.pos == `UCIE_POS_MID);

	// address decode; alternative indices only count when the map is selected
	function automatic logic hit(input logic [5:0] a, input logic [5:0] want, input logic alt);
		return (a == want) && (!alt || alt_map_select);
	endfunction

	//==================================================================
	// line sequencer
	assign sb.tick       = TICK32;
	assign sb.tx_on      = tx_rx_control[`UCIE_B_TXON];
	assign sb.break_send = tx_rx_control[`UCIE_B_BRKSND];
	assign sb.long_break = cfg[`UCIE_B_LBRK];
	assign sb.word9      = cfg[`UCIE_B_WL9];
	assign sb.data_bit   = TX_DATA_BIT;

	ucie_txseq u_seq (
		.clk  (CLK),
		.srst (SRST),
		.sb   (sb.seq)
	);

	//==================================================================
	// wishbone answer: one wait state, ack never held two cycles
	always_ff @(posedge CLK)
	begin
		if (SRST)
			WB_ACK <= 1'b0;
		else
			WB_ACK <= acc;
	end

	always_comb
	begin
		next_dat = 32'h0000_0000;
		if (hit(idx, `UCIE_IDX_ASTAT, 1'b1))
		begin
			next_dat[`UCIE_B_EDGE] = alt_flags[2];
			next_dat[`UCIE_B_BERV] = bit_err_val;
			next_dat[`UCIE_B_BERR] = alt_flags[1];
			next_dat[`UCIE_B_BRK]  = alt_flags[0];
		end
		else if (hit(idx, `UCIE_IDX_AIRQ, 1'b1))
			next_dat[7:0] = alt_irq_enable;
		else if (hit(idx, `UCIE_IDX_AFEAT, 1'b1))
			next_dat[7:0] = alt_feature_control;
		else if (hit(idx, `UCIE_IDX_CTRL, 1'b0))
			next_dat[7:0] = tx_rx_control;
		else if (hit(idx, `UCIE_IDX_CFG, 1'b0))
			next_dat[7:0] = cfg;
		else if (hit(idx, `UCIE_IDX_FLAGS, 1'b0))
			next_dat[4:0] = {IDLE_LINE, OVERRUN, RX_FULL, TX_DONE, TX_EMPTY};
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			WB_DAT_O <= 32'h0000_0000;
		else if (acc && !WB_WE)
			WB_DAT_O <= next_dat;
	end

	//==================================================================
	// registers written by software
	always_ff @(posedge CLK)
	begin
		if (SRST)
			alt_irq_enable <= `UCIE_RST_REG;
		else if (wr && hit(idx, `UCIE_IDX_AIRQ, 1'b1))
			alt_irq_enable <= WB_DAT_I[7:0];
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			alt_feature_control <= `UCIE_RST_REG;
		else if (wr && hit(idx, `UCIE_IDX_AFEAT, 1'b1))
			alt_feature_control <= WB_DAT_I[7:0];
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			cfg <= `UCIE_RST_REG;
		else if (wr && hit(idx, `UCIE_IDX_CFG, 1'b0))
			cfg <= {4'h0, WB_DAT_I[3:0]};
	end

	// a wakeup clears standby unless software writes the register that cycle
	always_ff @(posedge CLK)
	begin
		if (SRST)
			tx_rx_control <= `UCIE_RST_REG;
		else if (wr && hit(idx, `UCIE_IDX_CTRL, 1'b0))
			tx_rx_control <= WB_DAT_I[7:0];
		else if (WAKE_EVENT)
			tx_rx_control[`UCIE_B_SLEEP] <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			CTRL_STATE <= `UCIE_RST_REG;
		else
			CTRL_STATE <= tx_rx_control;
	end

	//==================================================================
	// events feeding the alternative flags
	always_ff @(posedge CLK)
	begin
		if (SRST)
			rx_prev <= 1'b1;
		else
			rx_prev <= RXD;
	end

	// polarity 0 reacts to a fall, polarity 1 to a rise
	assign alt_set[2] = (rx_prev ^ RXD) && (rx_prev ^ cfg[`UCIE_B_RPOL]);

	always_comb
	begin
		case (bit_err_mode)
			BERR_AT9:  berr_tick = TICK32 && (sb.pos == `UCIE_POS_S9);
			BERR_AT13: berr_tick = TICK32 && (sb.pos == `UCIE_POS_S13);
			default:   berr_tick = 1'b0;
		endcase
	end

	// checked only while the pin is ours; reserved mode checks nothing
	assign alt_set[1] = berr_tick && tx_rx_control[`UCIE_B_TXON] && (RXD != sb.line);

	always_ff @(posedge CLK)
	begin
		if (SRST)
			bit_err_val <= 1'b0;
		else if (alt_set[1])
			bit_err_val <= RXD;
	end

	// run of low samples taken mid-bit; the flag fires once per run
	always_ff @(posedge CLK)
	begin
		if (SRST)
			low_run <= 4'h0;
		else if (!alt_feature_control[`UCIE_B_BKDF] || !tx_rx_control[`UCIE_B_RXON])
			low_run <= 4'h0;
		else if (mid_tick)
		begin
			if (rx_lvl)
				low_run <= 4'h0;
			else if (low_run != ucie_frame_len(cfg[`UCIE_B_WL9]))
				low_run <= low_run + 4'h1;
		end
	end

	assign alt_set[0] = mid_tick && !rx_lvl && alt_feature_control[`UCIE_B_BKDF]
		&& tx_rx_control[`UCIE_B_RXON]
		&& (low_run == ucie_frame_len(cfg[`UCIE_B_WL9]) - 4'h1);

	// write-one-to-clear; a set in the same cycle wins
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_flag
			always_ff @(posedge CLK)
			begin
				if (SRST)
					alt_flags[i] <= 1'b0;
				else if (alt_set[i])
					alt_flags[i] <= 1'b1;
				else if (wr && hit(idx, `UCIE_IDX_ASTAT, 1'b1)
					&& WB_DAT_I[(i == 2) ? `UCIE_B_EDGE : i])
					alt_flags[i] <= 1'b0;
			end
		end
	endgenerate

	//==================================================================
	// interrupt request; standby silences the receiver's own flags
	always_comb
	begin
		next_irq = 1'b0;
		if (alt_irq_enable[`UCIE_B_EDGE] && alt_flags[2])
			next_irq = 1'b1;
		if (alt_irq_enable[`UCIE_B_BERR] && alt_flags[1])
			next_irq = 1'b1;
		if (alt_irq_enable[`UCIE_B_BRK] && alt_flags[0])
			next_irq = 1'b1;
		if (tx_rx_control[`UCIE_B_EMPTY_EN] && TX_EMPTY)
			next_irq = 1'b1;
		if (tx_rx_control[`UCIE_B_DONE_EN] && TX_DONE)
			next_irq = 1'b1;
		if (!tx_rx_control[`UCIE_B_SLEEP])
		begin
			if (tx_rx_control[`UCIE_B_FULL_EN] && (RX_FULL || OVERRUN))
				next_irq = 1'b1;
			if (tx_rx_control[`UCIE_B_IDLE_EN] && IDLE_LINE)
				next_irq = 1'b1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			IRQ <= 1'b0;
		else
			IRQ <= next_irq;
	end

	//==================================================================
	// transmit pin with optional narrow-pulse coding
	always_comb
	begin
		case (alt_feature_control[`UCIE_B_TNPH:`UCIE_B_TNPL])
			2'b01:   pulse_w = `UCIE_PW_1_16;
			2'b10:   pulse_w = `UCIE_PW_1_32;
			2'b11:   pulse_w = `UCIE_PW_1_4;
			default: pulse_w = `UCIE_PW_3_16;
		endcase
	end

	// in infrared mode a zero bit is a short high pulse at bit start
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			TXD_O  <= 1'b1;
			TXD_OE <= 1'b0;
		end
		else
		begin
			TXD_OE <= tx_rx_control[`UCIE_B_TXON];
			if (!tx_rx_control[`UCIE_B_TXON])
				TXD_O <= 1'b1;
			else if (alt_feature_control[`UCIE_B_IRON])
				TXD_O <= !sb.line && (sb.pos < pulse_w);
			else
				TXD_O <= sb.line;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			TX_BUSY <= 1'b0;
		else
			TX_BUSY <= sb.busy;
	end
endmodule
`default_nettype wire

// File: src/ucie_txseq.sv
// transmit line sequencer: idle preamble and break characters over the shifter's data
// assumes a 32-per-bit tick enable and the shifter's bit on data_bit while idle
`timescale 1ns/1ns
`default_nettype none
module ucie_txseq (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// control side
	ucie_seq_if.seq   sb
);
	import ucie_pkg::*;

	ucie_seq_t  state;
	logic [4:0] pos;
	logic [4:0] pos_q;
	logic [3:0] left;
	logic       on_prev;
	logic       brk_prev;
	logic       pre_pend;
	logic       brk_pend;
	logic       bit_end;
	logic       next_line;

	assign bit_end = sb.tick && (pos == `UCIE_TICK_LAST);
	assign sb.pos  = pos_q;
	assign sb.busy = (state != SEQ_IDLE);

	always_ff @(posedge clk)
	begin
		if (srst)
			pos <= 5'h00;
		else if (sb.tick)
			pos <= pos + 5'h01;
	end

	// the count goes out one cycle late so it lines up with the registered line;
	// otherwise a pulse would be clipped at break start and a stray one follow it
	always_ff @(posedge clk)
	begin
		if (srst)
			pos_q <= 5'h00;
		else
			pos_q <= pos;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			on_prev  <= 1'b0;
			brk_prev <= 1'b0;
		end
		else
		begin
			on_prev  <= sb.tx_on;
			brk_prev <= sb.break_send;
		end
	end

	// a fresh enable queues one preamble; the set beats a same-cycle start
	always_ff @(posedge clk)
	begin
		if (srst)
			pre_pend <= 1'b0;
		else if (sb.tx_on && !on_prev)
			pre_pend <= 1'b1;
		else if (!sb.tx_on || (bit_end && state == SEQ_IDLE && !brk_pend && !sb.break_send))
			pre_pend <= 1'b0;
	end

	// a short pulse on break_send still yields one whole break
	always_ff @(posedge clk)
	begin
		if (srst)
			brk_pend <= 1'b0;
		else if (sb.break_send && !brk_prev)
			brk_pend <= 1'b1;
		else if (!sb.tx_on || (bit_end && state == SEQ_IDLE))
			brk_pend <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= SEQ_IDLE;
			left  <= 4'h0;
		end
		else if (!sb.tx_on)
			state <= SEQ_IDLE;
		else if (bit_end)
		begin
			case (state)
				SEQ_IDLE:
				begin
					if (brk_pend || sb.break_send)
					begin
						state <= SEQ_BREAK;
						left  <= ucie_break_len(sb.word9, sb.long_break);
					end
					else if (pre_pend)
					begin
						state <= SEQ_PREAMBLE;
						left  <= ucie_frame_len(sb.word9);
					end
				end
				SEQ_PREAMBLE:
				begin
					left <= left - 4'h1;
					if (left == 4'h1)
						state <= SEQ_IDLE;
				end
				SEQ_BREAK:
				begin
					left <= left - 4'h1;
					if (left == 4'h1)
					begin
						if (sb.break_send)
							left <= ucie_break_len(sb.word9, sb.long_break);
						else
							state <= SEQ_IDLE;
					end
				end
				default:
					state <= SEQ_IDLE;
			endcase
		end
	end

	always_comb
	begin
		case (state)
			SEQ_BREAK:    next_line = 1'b0;
			SEQ_PREAMBLE: next_line = 1'b1;
			default:      next_line = sb.data_bit;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			sb.line <= 1'b1;
		else
			sb.line <= next_line;
	end
endmodule
`default_nettype wire

// File: tb/test_ucie_top.sv
// self-checking bench of the serial control block
// assumes ucie_top with its bound checker and the line model
`timescale 1ns/1ns
`default_nettype none
module test_ucie_top;
	import ucie_pkg::*;
	logic        CLK, SRST, WB_CYC, WB_STB, WB_WE, WB_ACK, TICK32, WAKE_EVENT;
	logic        RXD, TXD_O, TXD_OE, TX_BUSY, IRQ, flip, hold_low;
	logic [7:0]  WB_ADR, q, c;
	logic [3:0]  WB_SEL;
	logic [31:0] WB_DAT_I, WB_DAT_O;
	logic [4:0]  flg;
	ucie_reg_t   CTRL_STATE;
	int          err_total, total_checks, seed, cyc_n, lo_run, hi_run, last_lo, last_hi, len;
	int          pw[4] = '{6, 2, 1, 8};
	ucie_top i_ucie_top (.CLK(CLK), .SRST(SRST), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
		.WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
		.WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .RXD(RXD), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
		.TICK32(TICK32), .TX_DATA_BIT(1'b1), .WAKE_EVENT(WAKE_EVENT), .TX_EMPTY(flg[0]),
		.TX_DONE(flg[1]), .RX_FULL(flg[2]), .OVERRUN(flg[3]), .IDLE_LINE(flg[4]),
		.CTRL_STATE(CTRL_STATE), .TX_BUSY(TX_BUSY), .IRQ(IRQ));
	ucie_line_model i_ucie_line_model (.txd(TXD_O), .txd_oe(TXD_OE), .flip(flip),
		.hold_low(hold_low), .rxd(RXD));
	// ===========================================
	// clock, ticks, timeout, line run lengths
	initial
	begin
		CLK = 0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		TICK32 <= !TICK32;
		cyc_n++;
		if (TXD_O === 1'b0) lo_run++;
		else if (lo_run != 0)
		begin
			last_lo = lo_run;
			lo_run = 0;
		end
		if (TXD_O === 1'b1) hi_run++;
		else if (hi_run != 0)
		begin
			last_hi = hi_run;
			hi_run = 0;
		end
		if (cyc_n == 90000)
		begin
			err_total++;
			$display("mismatch at %0t: timeout", $time);
			close_out();
		end
	end
	// ===========================================
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
		@(posedge CLK);
		WB_CYC <= 1;
		WB_STB <= 1;
		WB_WE <= we;
		WB_ADR <= {idx, 2'b00};
		WB_DAT_I <= {24'h00_0000, d};
		do @(posedge CLK); while (WB_ACK !== 1'b1);
		q = WB_DAT_O[7:0];
		WB_CYC <= 0;
		WB_STB <= 0;
	endtask
	task rdchk(input logic [5:0] idx, input logic [7:0] exp);
		wb(0, idx, 8'h00);
		chk(q, exp);
	endtask
	task busy_done;
		wait (TX_BUSY === 1'b1);
		wait (TX_BUSY === 1'b0);
		repeat (4) @(posedge CLK);
	endtask
	function automatic logic exp_irq(input logic [7:0] r, input logic [4:0] f);
		return (r[7] & f[0]) | (r[6] & f[1]) | (r[5] & !r[1] & (f[2] | f[3])) | (r[4] & !r[1] & f[4]);
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ===========================================
	// main sequence
	initial
	begin
		{SRST, WB_CYC, WB_STB, WB_WE, TICK32, WAKE_EVENT, flip, hold_low} = 8'h80;
		{WB_ADR, WB_SEL, WB_DAT_I, flg} = '0;
		WB_SEL = 4'h1;
		seed = 32'h0520_095f;
		repeat (6) @(posedge CLK);
		SRST <= 0;
		rdchk(3, 8'h00);
		wb(1, 1, 8'h83);
		rdchk(1, 8'h00);
		wb(1, 8, 8'h01);
		rdchk(1, 8'h00);
		wb(1, 1, 8'h83);
		wb(1, 2, 8'he7);
		rdchk(1, 8'h83);
		wb(1, 8, 8'h00);
		rdchk(2, 8'h00);
		wb(1, 2, 8'h00);
		wb(1, 8, 8'h01);
		rdchk(2, 8'he7);
		wb(1, 1, 8'h00);
		wb(1, 2, 8'h00);
		for (int i = 0; i < 24; i++)
		begin
			c = (i == 0) ? 8'h22 : 8'($random(seed)) & 8'hf6;
			flg <= (i == 0) ? 5'h04 : 5'($random(seed));
			wb(1, 3, c);
			rdchk(3, c);
			rdchk(9, {3'h0, flg});
			chk(IRQ, exp_irq(c, flg));
		end
		// sleeping receiver wakes and its request passes
		flg <= 5'h04;
		wb(1, 3, 8'h22);
		@(posedge CLK) WAKE_EVENT <= 1;
		@(posedge CLK) WAKE_EVENT <= 0;
		repeat (3) @(posedge CLK);
		chk(IRQ, 1'b1);
		rdchk(3, 8'h20);
		flg <= 5'h00;
		wb(1, 3, 8'h00);
		// active edge, both polarities
		wb(1, 0, 8'hff);
		wb(1, 1, 8'h80);
		hold_low <= 1;
		repeat (3) @(posedge CLK);
		chk(IRQ, 1'b1);
		rdchk(0, 8'h80);
		wb(1, 8, 8'h09);
		wb(1, 0, 8'hff);
		@(posedge CLK);
		chk(IRQ, 1'b0);
		hold_low <= 0;
		repeat (3) @(posedge CLK);
		chk(IRQ, 1'b1);
		// bit error in each mode against a disagreeing echo
		wb(1, 8, 8'h01);
		wb(1, 1, 8'h02);
		wb(1, 3, 8'h08);
		busy_done();
		for (int m = 0; m < 4; m++)
		begin
			wb(1, 2, m[1:0] << 1);
			wb(1, 0, 8'hff);
			flip <= 1;
			repeat (200) @(posedge CLK);
			flip <= 0;
			repeat (3) @(posedge CLK);
			chk(IRQ, m == 1 || m == 2);
			rdchk(0, (m == 1 || m == 2) ? 8'h82 : 8'h80);
		end
		// break lengths, single and held, with break detection on the echo
		wb(1, 2, 8'h01);
		wb(1, 1, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			len = k[1] ? (k[0] ? 14 : 13) : (k[0] ? 11 : 10);
			wb(1, 8, {5'h00, k[0], k[1], 1'b1});
			wb(1, 0, 8'hff);
			wb(1, 3, 8'h0d);
			wb(1, 3, 8'h0c);
			busy_done();
			chk(last_lo, len * 64);
			chk(IRQ, 1'b1);
			wb(1, 3, 8'h0d);
			repeat (len * 64 + 200) @(posedge CLK);
			wb(1, 3, 8'h0c);
			busy_done();
			chk(last_lo, 2 * len * 64);
		end
		// infrared pulse widths on a break
		wb(1, 8, 8'h01);
		for (int p = 0; p < 4; p++)
		begin
			wb(1, 2, {1'b1, p[1:0], 5'h00});
			last_hi = 0;
			wb(1, 3, 8'h09);
			wb(1, 3, 8'h08);
			busy_done();
			chk(last_hi, pw[p] * 2);
		end
		close_out();
	end
endmodule
`default_nettype wire

// File: tb/ucie_line_model.sv
// remote node on the serial line: echoes the transmit pin onto receive
// assumes a pull-up on the line while the transmit pin is released
`timescale 1ns/1ns
`default_nettype none
module ucie_line_model (
	// line
	input  wire logic txd,
	input  wire logic txd_oe,
	// faults commanded by the bench
	input  wire logic flip,
	input  wire logic hold_low,
	output logic      rxd
);
	// flip makes the echo disagree with what was sent
	assign rxd = hold_low ? 1'b0 : (txd_oe ? txd ^ flip : 1'b1);
endmodule
`default_nettype wire

// File: tb/ucie_top_properties.sv
// port checker of the serial control block, bound onto its top module
// assumes TICK32 on every second clock, so one bit lasts 64 clocks
`timescale 1ns/1ns
`default_nettype none
`include "ucie_defs.svh"
module ucie_top_chk import ucie_pkg::*; (
	// clock and reset
	input wire logic                CLK,
	input wire logic                SRST,
	// wishbone
	input wire logic                WB_CYC,
	input wire logic                WB_STB,
	input wire logic                WB_WE,
	input wire logic [7:0]          WB_ADR,
	input wire logic [3:0]          WB_SEL,
	input wire logic [31:0]         WB_DAT_I,
	input wire logic [31:0]         WB_DAT_O,
	input wire logic                WB_ACK,
	// line, flags and controls
	input wire logic                TXD_OE,
	input wire logic                TX_EMPTY,
	input wire logic                RX_FULL,
	input wire logic                OVERRUN,
	input wire logic                IDLE_LINE,
	input wire ucie_pkg::ucie_reg_t CTRL_STATE,
	input wire logic                TX_BUSY,
	input wire logic                IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// ===========================================
	// bus
	sequence s_take;
		WB_CYC && WB_STB && !WB_ACK;
	endsequence
	sequence s_ctrl_wr;
		s_take ##0 (WB_WE && WB_SEL[0] && WB_ADR[7:2] == `UCIE_IDX_CTRL);
	endsequence
	property p_ack_answer;
		s_take |=> WB_ACK ##1 !WB_ACK;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack not single");
	property p_dat_hi;
		WB_ACK |-> WB_DAT_O[31:8] == 24'h00_0000;
	endproperty
	a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
	// sleep bit masked: a wakeup may clear it
	property p_ctrl_wr;
		s_ctrl_wr |-> ##2 ({CTRL_STATE[7:2], CTRL_STATE[0]} ==
			{$past(WB_DAT_I[7:2], 2), $past(WB_DAT_I[0], 2)});
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
	// ===========================================
	// request gating; the copy may lag the register, hence two cycles
	property p_irq_tx_empty;
		(CTRL_STATE[7] && TX_EMPTY) ##1 CTRL_STATE[7] |-> IRQ;
	endproperty
	a_irq_tx_empty: assert property (p_irq_tx_empty) else $error("no tx empty irq");
	property p_irq_rx;
		(CTRL_STATE[5] && !CTRL_STATE[1] && (RX_FULL || OVERRUN))
			##1 (CTRL_STATE[5] && !CTRL_STATE[1]) |-> IRQ;
	endproperty
	a_irq_rx: assert property (p_irq_rx) else $error("no rx irq");
	property p_irq_idle;
		(CTRL_STATE[4] && !CTRL_STATE[1] && IDLE_LINE) ##1 (CTRL_STATE[4] && !CTRL_STATE[1]) |-> IRQ;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("no idle irq");
	// ===========================================
	// transmit pin and sequencer
	property p_oe_on;
		CTRL_STATE[3] [*2] |-> TXD_OE;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not driven");
	property p_oe_off;
		!CTRL_STATE[3] [*2] |-> !TXD_OE;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven while off");
	property p_busy_pre;
		$rose(CTRL_STATE[3]) |-> ##[1:80] TX_BUSY;
	endproperty
	a_busy_pre: assert property (p_busy_pre) else $error("no preamble");
	property p_busy_brk;
		$rose(CTRL_STATE[0]) && CTRL_STATE[3] |-> ##[1:80] TX_BUSY;
	endproperty
	a_busy_brk: assert property (p_busy_brk) else $error("no break");
endmodule
bind ucie_top ucie_top_chk i_ucie_top_chk (
	.CLK(CLK), .SRST(SRST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
	.WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK(WB_ACK), .TXD_OE(TXD_OE), .TX_EMPTY(TX_EMPTY), .RX_FULL(RX_FULL),
	.OVERRUN(OVERRUN), .IDLE_LINE(IDLE_LINE), .CTRL_STATE(CTRL_STATE),
	.TX_BUSY(TX_BUSY), .IRQ(IRQ)
);
`default_nettype wire
